// ---- core/dcs_setup_regs.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Keep 32-bit foreground color; use low bits per pixel depth when selected.
// - Keep 32-bit background color; use low bits per pixel depth when selected.
// - Width or line length register holds count minus one, range 0..4095.
// - Height register holds height minus one, range 0..4095.
// - Mask origin X/Y offsets relative to destination origin, range 0..4095.
// - Source X/Y coordinates readable and writable, range 0..4095.
// - Pattern X/Y coordinates readable and writable, range 0..4095.
// - Destination X/Y are signed 16-bit, range -2048..6143.
// - Pixel op control holds unchanged while an operation runs.
// - Big-endian view swaps byte lanes of the pixel op register.
// - Writing the top byte of pixel op control starts a line or block transfer operation.
// - Background select 00 color, 10 source map, others reserved.
// - Foreground select 00 color, 10 source map, others reserved.
// - Function codes decode to line-step, line, and block transfer kinds.
// - Line-step functions start only on line-step register top byte write.
// - Source map field picks map A, B or C.
// - Destination map field picks map A, B or C.
// - Pattern code 1000 forces pattern one everywhere.
// - Pattern code 1001 derives pattern from source pixel nonzero.
// - Mask mode 00 disables mask, 01 boundary mode.
// - Draw style selects all, first null, last null, area boundary.
// - Octant bits are x direction, y direction, axis swap.
// - Line-step starts when its byte 3 is written.
module dcs_setup_regs #(
  parameter int MAX_BPP = 32
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic big_endian_i,
  input wire logic [6:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wbe_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [5:0] bpp_log2_i,
  input wire logic src_pixel_nonzero_i,
  input wire logic op_done_i,
  output logic busy_o,
  output logic start_o,
  output logic [3:0] func_o,
  output logic line_step_o,
  output logic is_line_o,
  output logic is_block_o,
  output logic invert_o,
  output logic area_fill_o,
  output logic [31:0] fg_value_o,
  output logic [31:0] bg_value_o,
  output logic fg_from_src_o,
  output logic bg_from_src_o,
  output logic [1:0] src_map_o,
  output logic [1:0] dst_map_o,
  output logic pattern_o,
  output logic pattern_fixed_o,
  output logic mask_enable_o,
  output logic [1:0] line_draw_style_o,
  output logic x_direction_bit_o,
  output logic y_direction_bit_o,
  output logic axis_swap_bit_o,
  output logic [15:0] op_width_o,
  output logic [15:0] op_height_o,
  output logic [15:0] mask_origin_x_o,
  output logic [15:0] mask_origin_y_o,
  output logic [15:0] source_x_o,
  output logic [15:0] source_y_o,
  output logic [15:0] pattern_x_o,
  output logic [15:0] pattern_y_o,
  output logic [15:0] dest_x_o,
  output logic [15:0] dest_y_o
);

  // Depth masks wider than one 32-bit word cannot be served
  if (MAX_BPP < 1 || MAX_BPP > 32) begin : g_bad_bpp
    $error("MAX_BPP must lie in 1..32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Swap byte lanes for the big-endian register view
  function automatic logic [31:0] lane_swap(input logic [31:0] w);
    lane_swap = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction : lane_swap

  function automatic logic [3:0] lane_swap_be(input logic [3:0] b);
    lane_swap_be = {b[0], b[1], b[2], b[3]};
  endfunction : lane_swap_be

  // Merge byte-enabled write data into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    merge = r;
  endfunction : merge

  // Merge byte-enabled data into one 16-bit half register
  function automatic logic [15:0] merge_half(input logic [15:0] old, input logic [15:0] d, input logic [1:0] be);
    logic [15:0] r;
    r = old;
    for (int i = 0; i < 2; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    merge_half = r;
  endfunction : merge_half

  // Keep only the pixel-depth low bits of a color
  function automatic logic [31:0] depth_mask(input logic [31:0] c, input logic [5:0] l2);
    logic [31:0] m;
    m = (l2 >= 6'h05) ? 32'hFFFF_FFFF : ((32'h0000_0001 << (32'h0000_0001 << l2)) - 32'h0000_0001);
    depth_mask = c & m;
  endfunction : depth_mask

  function automatic logic [1:0] map_code(input logic [3:0] f);
    case (f)
      dcs_pkg::MAP_A: map_code = 2'h1;
      dcs_pkg::MAP_B: map_code = 2'h2;
      dcs_pkg::MAP_C: map_code = 2'h3;
      default: map_code = 2'h0;
    endcase
  endfunction : map_code

  function automatic logic func_valid(input logic [3:0] f);
    case (f)
      dcs_pkg::FN_STEP_READ, dcs_pkg::FN_LINE_READ, dcs_pkg::FN_STEP_WRITE, dcs_pkg::FN_LINE_WRITE,
      dcs_pkg::FN_BLOCK, dcs_pkg::FN_BLOCK_INV, dcs_pkg::FN_BLOCK_FILL: func_valid = 1'b1;
      default: func_valid = 1'b0;
    endcase
  endfunction : func_valid

  function automatic logic func_is_step(input logic [3:0] f);
    func_is_step = (f == dcs_pkg::FN_STEP_READ) || (f == dcs_pkg::FN_STEP_WRITE);
  endfunction : func_is_step

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  logic [6:0] word_addr;
  logic wr_hit_lo;
  logic wr_hit_hi;
  logic [31:0] fg_color_r;
  logic [31:0] bg_color_r;
  logic [15:0] op_width_r;
  logic [15:0] op_height_r;
  logic [15:0] mask_x_r;
  logic [15:0] mask_y_r;
  logic [15:0] src_x_r;
  logic [15:0] src_y_r;
  logic [15:0] pat_x_r;
  logic [15:0] pat_y_r;
  logic [15:0] dst_x_r;
  logic [15:0] dst_y_r;
  logic [31:0] pixel_op_r;
  logic [31:0] pixel_op_nxt;
  logic [31:0] le_data;
  logic [3:0] le_be;
  logic op_write;
  logic step_write;
  dcs_pkg::dcs_state_t state_r;

  assign word_addr = {addr_i[6:2], 2'h0};
  // Word lanes: bytes 1:0 hold the lower half register, 3:2 the upper
  assign wr_hit_lo = wr_i && (wbe_i[1:0] != 2'h0);
  assign wr_hit_hi = wr_i && (wbe_i[3:2] != 2'h0);
  assign le_data = big_endian_i ? lane_swap(wdata_i) : wdata_i;
  assign le_be = big_endian_i ? lane_swap_be(wbe_i) : wbe_i;
  assign op_write = wr_i && (word_addr == dcs_pkg::OFS_PIXEL_OP);
  assign step_write = wr_i && (word_addr == dcs_pkg::OFS_LINE_STEP) && le_be[3];

  ////////////////////////////////////////////////////////////////////////////
  // Parameter registers

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      fg_color_r <= dcs_pkg::RESET_WORD;
      bg_color_r <= dcs_pkg::RESET_WORD;
    end else if (wr_i) begin
      if (word_addr == dcs_pkg::OFS_FG_COLOR) begin
        fg_color_r <= merge(fg_color_r, wdata_i, wbe_i);
      end
      if (word_addr == dcs_pkg::OFS_BG_COLOR) begin
        bg_color_r <= merge(bg_color_r, wdata_i, wbe_i);
      end
    end
  end

  // Two 16-bit registers share each word; the enabled lanes pick which one
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      op_width_r <= dcs_pkg::RESET_HALF;
      op_height_r <= dcs_pkg::RESET_HALF;
      mask_x_r <= dcs_pkg::RESET_HALF;
      mask_y_r <= dcs_pkg::RESET_HALF;
      src_x_r <= dcs_pkg::RESET_HALF;
      src_y_r <= dcs_pkg::RESET_HALF;
      pat_x_r <= dcs_pkg::RESET_HALF;
      pat_y_r <= dcs_pkg::RESET_HALF;
      dst_x_r <= dcs_pkg::RESET_HALF;
      dst_y_r <= dcs_pkg::RESET_HALF;
    end else begin
      case (word_addr)
        dcs_pkg::OFS_OP_WIDTH: begin
          if (wr_hit_lo) op_width_r <= merge_half(op_width_r, wdata_i[15:0], wbe_i[1:0]);
          if (wr_hit_hi) op_height_r <= merge_half(op_height_r, wdata_i[31:16], wbe_i[3:2]);
        end
        dcs_pkg::OFS_MASK_X: begin
          if (wr_hit_lo) mask_x_r <= merge_half(mask_x_r, wdata_i[15:0], wbe_i[1:0]);
          if (wr_hit_hi) mask_y_r <= merge_half(mask_y_r, wdata_i[31:16], wbe_i[3:2]);
        end
        dcs_pkg::OFS_SRC_X: begin
          if (wr_hit_lo) src_x_r <= merge_half(src_x_r, wdata_i[15:0], wbe_i[1:0]);
          if (wr_hit_hi) src_y_r <= merge_half(src_y_r, wdata_i[31:16], wbe_i[3:2]);
        end
        dcs_pkg::OFS_PAT_X: begin
          if (wr_hit_lo) pat_x_r <= merge_half(pat_x_r, wdata_i[15:0], wbe_i[1:0]);
          if (wr_hit_hi) pat_y_r <= merge_half(pat_y_r, wdata_i[31:16], wbe_i[3:2]);
        end
        dcs_pkg::OFS_DST_X: begin
          if (wr_hit_lo) dst_x_r <= merge_half(dst_x_r, wdata_i[15:0], wbe_i[1:0]);
          if (wr_hit_hi) dst_y_r <= merge_half(dst_y_r, wdata_i[31:16], wbe_i[3:2]);
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel operation control and launch

  // Writes while busy are dropped so the running operation keeps its setup
  always_comb begin
    pixel_op_nxt = merge(pixel_op_r, le_data, le_be);
  end

  // A reserved function byte discards the whole access
  logic op_accept;
  assign op_accept = op_write && (state_r == dcs_pkg::ST_IDLE) &&
    (!le_be[3] || func_valid(pixel_op_nxt[dcs_pkg::FUNC_LSB +: 4]));

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pixel_op_r <= dcs_pkg::RESET_WORD;
    end else if (op_accept) begin
      pixel_op_r <= pixel_op_nxt;
    end
  end

  logic launch_op;
  logic launch_step;
  assign launch_op = op_accept && le_be[3] && !func_is_step(pixel_op_nxt[dcs_pkg::FUNC_LSB +: 4]);
  assign launch_step = step_write && (state_r == dcs_pkg::ST_IDLE) &&
    func_is_step(pixel_op_r[dcs_pkg::FUNC_LSB +: 4]);

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_r <= dcs_pkg::ST_IDLE;
      start_o <= 1'b0;
    end else begin
      start_o <= launch_op || launch_step;
      case (state_r)
        dcs_pkg::ST_IDLE: if (launch_op || launch_step) state_r <= dcs_pkg::ST_BUSY;
        dcs_pkg::ST_BUSY: if (op_done_i) state_r <= dcs_pkg::ST_IDLE;
        default: state_r <= dcs_pkg::ST_IDLE;
      endcase
    end
  end

  assign busy_o = (state_r == dcs_pkg::ST_BUSY);

  ////////////////////////////////////////////////////////////////////////////
  // Field decode toward the datapath

  logic [3:0] func_f;
  logic [1:0] bg_sel_f;
  logic [1:0] fg_sel_f;
  logic [3:0] pat_f;
  logic [1:0] mask_f;
  assign func_f = pixel_op_r[dcs_pkg::FUNC_LSB +: 4];
  assign bg_sel_f = pixel_op_r[dcs_pkg::BG_SEL_LSB +: 2];
  assign fg_sel_f = pixel_op_r[dcs_pkg::FG_SEL_LSB +: 2];
  assign pat_f = pixel_op_r[dcs_pkg::PAT_MAP_LSB +: 4];
  assign mask_f = pixel_op_r[dcs_pkg::MASK_MODE_LSB +: 2];

  assign func_o = func_f;
  assign line_step_o = func_is_step(func_f);
  assign is_line_o = (func_f == dcs_pkg::FN_LINE_READ) || (func_f == dcs_pkg::FN_LINE_WRITE);
  assign is_block_o = (func_f == dcs_pkg::FN_BLOCK) || (func_f == dcs_pkg::FN_BLOCK_INV) ||
    (func_f == dcs_pkg::FN_BLOCK_FILL);
  assign invert_o = (func_f == dcs_pkg::FN_BLOCK_INV);
  assign area_fill_o = (func_f == dcs_pkg::FN_BLOCK_FILL);
  assign fg_from_src_o = (fg_sel_f == dcs_pkg::SEL_SRC_MAP);
  assign bg_from_src_o = (bg_sel_f == dcs_pkg::SEL_SRC_MAP);
  // Only the color choice drives a value; reserved or map codes give zero
  assign fg_value_o = (fg_sel_f == dcs_pkg::SEL_COLOR) ? depth_mask(fg_color_r, bpp_log2_i) : 32'h0;
  assign bg_value_o = (bg_sel_f == dcs_pkg::SEL_COLOR) ? depth_mask(bg_color_r, bpp_log2_i) : 32'h0;
  assign src_map_o = map_code(pixel_op_r[dcs_pkg::SRC_MAP_LSB +: 4]);
  assign dst_map_o = map_code(pixel_op_r[dcs_pkg::DST_MAP_LSB +: 4]);
  assign pattern_fixed_o = (pat_f == dcs_pkg::PAT_ALL_ONE) || (pat_f == dcs_pkg::PAT_FROM_SRC);
  // Other pattern codes name a map and come from the datapath; shown as one here
  assign pattern_o = (pat_f == dcs_pkg::PAT_FROM_SRC) ? src_pixel_nonzero_i : 1'b1;
  assign mask_enable_o = (mask_f == dcs_pkg::MASK_BOUNDARY);
  assign line_draw_style_o = pixel_op_r[dcs_pkg::DRAW_STYLE_LSB +: 2];
  assign x_direction_bit_o = pixel_op_r[dcs_pkg::OCTANT_LSB + 2];
  assign y_direction_bit_o = pixel_op_r[dcs_pkg::OCTANT_LSB + 1];
  assign axis_swap_bit_o = pixel_op_r[dcs_pkg::OCTANT_LSB];

  assign op_width_o = op_width_r;
  assign op_height_o = op_height_r;
  assign mask_origin_x_o = mask_x_r;
  assign mask_origin_y_o = mask_y_r;
  assign source_x_o = src_x_r;
  assign source_y_o = src_y_r;
  assign pattern_x_o = pat_x_r;
  assign pattern_y_o = pat_y_r;
  assign dest_x_o = dst_x_r;
  assign dest_y_o = dst_y_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read back; write-only locations return zero

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_o <= dcs_pkg::RESET_WORD;
    end else if (rd_i) begin
      case (word_addr)
        dcs_pkg::OFS_SRC_X: rdata_o <= {src_y_r, src_x_r};
        dcs_pkg::OFS_PAT_X: rdata_o <= {pat_y_r, pat_x_r};
        dcs_pkg::OFS_DST_X: rdata_o <= {dst_y_r, dst_x_r};
        default: rdata_o <= dcs_pkg::RESET_WORD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_op_hold: assert property (@(posedge clock_i) disable iff (rst_i)
    busy_o |=> $stable(pixel_op_r)) else $error("pixel op changed while busy");
  chk_launch_pulse: assert property (@(posedge clock_i) disable iff (rst_i)
    (launch_op || launch_step) |=> start_o && busy_o) else $error("launch did not start");
  chk_reserved_no_start: assert property (@(posedge clock_i) disable iff (rst_i)
    (op_write && le_be[3] && !func_valid(pixel_op_nxt[dcs_pkg::FUNC_LSB +: 4])) |=> !start_o && $stable(pixel_op_r))
    else $error("reserved code acted");
  chk_step_no_op: assert property (@(posedge clock_i) disable iff (rst_i)
    (op_accept && func_is_step(pixel_op_nxt[dcs_pkg::FUNC_LSB +: 4]) && !step_write) |=> !start_o)
    else $error("line-step started by pixel op write");
  chk_step_start: assert property (@(posedge clock_i) disable iff (rst_i)
    (step_write && !busy_o && line_step_o) |=> start_o) else $error("line-step write ignored");
  // Hosts leave one idle cycle between a write and the read that follows it
  chk_src_readback: assert property (@(posedge clock_i) disable iff (rst_i)
    (wr_i && wbe_i == 4'hF && word_addr == dcs_pkg::OFS_SRC_X) ##1 !wr_i ##1
    (rd_i && word_addr == dcs_pkg::OFS_SRC_X && !wr_i) |=> rdata_o == $past(wdata_i, 3))
    else $error("source readback mismatch");
  chk_fg_depth: assert property (@(posedge clock_i) disable iff (rst_i)
    (fg_sel_f == dcs_pkg::SEL_COLOR && bpp_log2_i == 6'h02) |-> fg_value_o == {28'h0, fg_color_r[3:0]})
    else $error("foreground depth mask wrong");
  chk_pattern_src: assert property (@(posedge clock_i) disable iff (rst_i)
    (pat_f == dcs_pkg::PAT_FROM_SRC) |-> pattern_o == src_pixel_nonzero_i) else $error("pattern source wrong");
  chk_pattern_one: assert property (@(posedge clock_i) disable iff (rst_i)
    (pat_f == dcs_pkg::PAT_ALL_ONE) |-> pattern_o) else $error("pattern not forced one");

endmodule : dcs_setup_regs

// ---- core/dcs_pkg.sv ----
package dcs_pkg;
  // Byte offsets within the register bank
  localparam logic [6:0] OFS_FG_COLOR = 7'h58;
  localparam logic [6:0] OFS_BG_COLOR = 7'h5C;
  localparam logic [6:0] OFS_OP_WIDTH = 7'h60;
  localparam logic [6:0] OFS_OP_HEIGHT = 7'h62;
  localparam logic [6:0] OFS_MASK_X = 7'h6C;
  localparam logic [6:0] OFS_MASK_Y = 7'h6E;
  localparam logic [6:0] OFS_SRC_X = 7'h70;
  localparam logic [6:0] OFS_SRC_Y = 7'h72;
  localparam logic [6:0] OFS_PAT_X = 7'h74;
  localparam logic [6:0] OFS_PAT_Y = 7'h76;
  localparam logic [6:0] OFS_DST_X = 7'h78;
  localparam logic [6:0] OFS_DST_Y = 7'h7A;
  localparam logic [6:0] OFS_PIXEL_OP = 7'h7C;
  localparam logic [6:0] OFS_LINE_STEP = 7'h2C;
  // Field positions in the little-endian view of the pixel op word
  localparam int BG_SEL_LSB = 30;
  localparam int FG_SEL_LSB = 28;
  localparam int FUNC_LSB = 24;
  localparam int SRC_MAP_LSB = 20;
  localparam int DST_MAP_LSB = 16;
  localparam int PAT_MAP_LSB = 12;
  localparam int MASK_MODE_LSB = 6;
  localparam int DRAW_STYLE_LSB = 4;
  localparam int OCTANT_LSB = 0;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [15:0] RESET_HALF = 16'h0000;
  // Source selects
  localparam logic [1:0] SEL_COLOR = 2'h0;
  localparam logic [1:0] SEL_SRC_MAP = 2'h2;
  // Map selects
  localparam logic [3:0] MAP_A = 4'h1;
  localparam logic [3:0] MAP_B = 4'h2;
  localparam logic [3:0] MAP_C = 4'h3;
  localparam logic [3:0] PAT_ALL_ONE = 4'h8;
  localparam logic [3:0] PAT_FROM_SRC = 4'h9;
  localparam logic [1:0] MASK_OFF = 2'h0;
  localparam logic [1:0] MASK_BOUNDARY = 2'h1;
  typedef enum logic [3:0] {
    FN_STEP_READ = 4'h2,
    FN_LINE_READ = 4'h3,
    FN_STEP_WRITE = 4'h4,
    FN_LINE_WRITE = 4'h5,
    FN_BLOCK = 4'h8,
    FN_BLOCK_INV = 4'h9,
    FN_BLOCK_FILL = 4'hA
  } dcs_func_t;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BUSY
  } dcs_state_t;
endpackage : dcs_pkg

// ---- tb/dcs_host_model.sv ----
`timescale 1ns/1ps
// Host side of the register bank: one access per call, strobes launched after a falling edge
module dcs_host_model (
  input wire logic clock_i,
  input wire logic [31:0] rdata_i,
  output logic [6:0] addr_o,
  output logic [31:0] wdata_o,
  output logic [3:0] wbe_o,
  output logic wr_o,
  output logic rd_o
);
  initial begin
    addr_o = 7'h00;
    wdata_o = 32'h0000_0000;
    wbe_o = 4'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  task automatic write_reg(input logic [6:0] a, input logic [31:0] d, input logic [3:0] be);
    @(negedge clock_i);
    addr_o = a;
    wdata_o = d;
    wbe_o = be;
    wr_o = 1'b1;
    @(negedge clock_i);
    wr_o = 1'b0;
    // Released lanes never keep the last value
    wdata_o = ~d;
  endtask : write_reg

  task automatic read_reg(input logic [6:0] a, output logic [31:0] d);
    @(negedge clock_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clock_i);
    rd_o = 1'b0;
    d = rdata_i;
  endtask : read_reg
endmodule : dcs_host_model

// ---- tb/test_dcs_setup_regs.sv ----
`timescale 1ns/1ps
module test_dcs_setup_regs;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic big_endian_i = 1'b0;
  logic [5:0] bpp_log2_i = 6'h00;
  logic src_pixel_nonzero_i = 1'b0;
  logic op_done_i = 1'b0;
  logic [6:0] addr_i;
  logic [31:0] wdata_i, rdata_o, fg_value_o, bg_value_o;
  logic [3:0] wbe_i, func_o;
  logic wr_i, rd_i, busy_o, start_o, line_step_o, is_line_o, is_block_o, invert_o, area_fill_o;
  logic fg_from_src_o, bg_from_src_o, pattern_o, pattern_fixed_o, mask_enable_o;
  logic x_direction_bit_o, y_direction_bit_o, axis_swap_bit_o;
  logic [1:0] src_map_o, dst_map_o, line_draw_style_o;
  logic [15:0] op_width_o, op_height_o, mask_origin_x_o, mask_origin_y_o;
  logic [15:0] source_x_o, source_y_o, pattern_x_o, pattern_y_o, dest_x_o, dest_y_o;
  int err_count = 0;
  int checks = 0;
  logic [31:0] m_pop, m_fg, m_bg;
  logic m_busy;
  logic [15:0] m_half [logic [6:0]];
  logic [6:0] words [5] = '{7'h60, 7'h6C, 7'h70, 7'h74, 7'h78};

  always #50 clock_i = ~clock_i;

  dcs_setup_regs uut (.clock_i(clock_i), .rst_i(rst_i), .big_endian_i(big_endian_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wbe_i(wbe_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .bpp_log2_i(bpp_log2_i),
    .src_pixel_nonzero_i(src_pixel_nonzero_i), .op_done_i(op_done_i), .busy_o(busy_o), .start_o(start_o),
    .func_o(func_o), .line_step_o(line_step_o), .is_line_o(is_line_o), .is_block_o(is_block_o),
    .invert_o(invert_o), .area_fill_o(area_fill_o), .fg_value_o(fg_value_o), .bg_value_o(bg_value_o),
    .fg_from_src_o(fg_from_src_o), .bg_from_src_o(bg_from_src_o), .src_map_o(src_map_o),
    .dst_map_o(dst_map_o), .pattern_o(pattern_o), .pattern_fixed_o(pattern_fixed_o),
    .mask_enable_o(mask_enable_o), .line_draw_style_o(line_draw_style_o),
    .x_direction_bit_o(x_direction_bit_o), .y_direction_bit_o(y_direction_bit_o),
    .axis_swap_bit_o(axis_swap_bit_o), .op_width_o(op_width_o), .op_height_o(op_height_o),
    .mask_origin_x_o(mask_origin_x_o), .mask_origin_y_o(mask_origin_y_o), .source_x_o(source_x_o),
    .source_y_o(source_y_o), .pattern_x_o(pattern_x_o), .pattern_y_o(pattern_y_o), .dest_x_o(dest_x_o),
    .dest_y_o(dest_y_o));

  dcs_host_model host (.clock_i(clock_i), .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i),
    .wbe_o(wbe_i), .wr_o(wr_i), .rd_o(rd_i));

  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      if (be[i]) o[8*i +: 8] = d[8*i +: 8];
    end
    return o;
  endfunction : merge

  function automatic logic [31:0] swap32(input logic [31:0] d);
    return {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction : swap32

  function automatic logic [1:0] map_of(input logic [3:0] v);
    return (v inside {4'h1, 4'h2, 4'h3}) ? v[1:0] : 2'h0;
  endfunction : map_of

  // Returns the expected start pulse of one write
  function automatic logic m_write(input logic [6:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] w, hw;
    logic [3:0] b;
    w = big_endian_i ? swap32(d) : d;
    b = big_endian_i ? {be[0], be[1], be[2], be[3]} : be;
    m_write = 1'b0;
    if (a == dcs_pkg::OFS_FG_COLOR) m_fg = merge(m_fg, d, be);
    else if (a == dcs_pkg::OFS_BG_COLOR) m_bg = merge(m_bg, d, be);
    else if (a == dcs_pkg::OFS_PIXEL_OP) begin
      if (!m_busy && !(b[3] && !(w[27:24] inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA}))) begin
        m_pop = merge(m_pop, w, b);
        m_write = b[3] && (w[27:24] inside {4'h3, 4'h5, 4'h8, 4'h9, 4'hA});
      end
    end else if (a == dcs_pkg::OFS_LINE_STEP) begin
      m_write = be[3] && !m_busy && (m_pop[27:24] inside {4'h2, 4'h4});
    end else if (a inside {7'h60, 7'h6C, 7'h70, 7'h74, 7'h78}) begin
      hw = merge({m_half[a + 7'h02], m_half[a]}, d, be);
      m_half[a] = hw[15:0];
      m_half[a + 7'h02] = hw[31:16];
    end
    if (m_write) m_busy = 1'b1;
  endfunction : m_write

  ////////////////////////////////////////////////////////////////
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_word

  task automatic check_flag(input logic got, input logic exp, input string what);
    check_word({31'h0, got}, {31'h0, exp}, what);
  endtask : check_flag

  task automatic do_write(input logic [6:0] a, input logic [31:0] d, input logic [3:0] be);
    logic e;
    e = m_write(a, d, be);
    host.write_reg(a, d, be);
    check_flag(start_o, e, "start");
    check_flag(busy_o, m_busy, "busy");
  endtask : do_write

  task automatic do_read(input logic [6:0] a);
    logic [31:0] d, e;
    e = (a inside {7'h70, 7'h74, 7'h78}) ? {m_half[a + 7'h02], m_half[a]} : 32'h0;
    host.read_reg(a, d);
    check_word(d, e, "read");
  endtask : do_read

  task automatic finish_op();
    @(negedge clock_i);
    op_done_i = 1'b1;
    @(negedge clock_i);
    op_done_i = 1'b0;
    m_busy = 1'b0;
    check_flag(busy_o, 1'b0, "busy after done");
  endtask : finish_op

  task automatic check_all();
    logic [3:0] f, p;
    logic [31:0] msk;
    f = m_pop[27:24];
    p = m_pop[15:12];
    msk = (bpp_log2_i == 6'h05) ? 32'hFFFF_FFFF : (32'h1 << (32'h1 << bpp_log2_i)) - 32'h1;
    check_word(32'(func_o), 32'(f), "func");
    check_flag(line_step_o, f inside {4'h2, 4'h4}, "step");
    check_flag(is_line_o, f inside {4'h3, 4'h5}, "line");
    check_flag(is_block_o, f inside {4'h8, 4'h9, 4'hA}, "block");
    check_flag(invert_o, f == 4'h9, "invert");
    check_flag(area_fill_o, f == 4'hA, "fill");
    check_word(fg_value_o, (m_pop[29:28] == 2'h0) ? (m_fg & msk) : 32'h0, "fg");
    check_word(bg_value_o, (m_pop[31:30] == 2'h0) ? (m_bg & msk) : 32'h0, "bg");
    check_flag(fg_from_src_o, m_pop[29:28] == 2'h2, "fg src");
    check_flag(bg_from_src_o, m_pop[31:30] == 2'h2, "bg src");
    check_word(32'(src_map_o), 32'(map_of(m_pop[23:20])), "src map");
    check_word(32'(dst_map_o), 32'(map_of(m_pop[19:16])), "dst map");
    check_flag(pattern_o, (p == 4'h9) ? src_pixel_nonzero_i : 1'b1, "pattern");
    check_flag(pattern_fixed_o, p inside {4'h8, 4'h9}, "fixed");
    check_flag(mask_enable_o, m_pop[7:6] == 2'h1, "mask");
    check_word(32'(line_draw_style_o), 32'(m_pop[5:4]), "style");
    check_word(32'({x_direction_bit_o, y_direction_bit_o, axis_swap_bit_o}), 32'(m_pop[2:0]), "oct");
    check_word({op_height_o, op_width_o}, {m_half[7'h62], m_half[7'h60]}, "dims");
    check_word({mask_origin_y_o, mask_origin_x_o}, {m_half[7'h6E], m_half[7'h6C]}, "mask org");
    check_word({source_y_o, source_x_o}, {m_half[7'h72], m_half[7'h70]}, "src xy");
    check_word({pattern_y_o, pattern_x_o}, {m_half[7'h76], m_half[7'h74]}, "pat xy");
    check_word({dest_y_o, dest_x_o}, {m_half[7'h7A], m_half[7'h78]}, "dst xy");
  endtask : check_all

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////
  // Whole run is about three hundred cycles; twenty thousand leaves ample margin
  initial begin
    #(20000 * 100);
    err_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    logic [31:0] w, d;
    logic [15:0] lo, hi;
    logic [6:0] a;
    int l;
    void'($urandom(32'h5E9B7724));
    m_pop = 32'h0;
    m_fg = 32'h0;
    m_bg = 32'h0;
    m_busy = 1'b0;
    foreach (words[i]) begin
      m_half[words[i]] = 16'h0000;
      m_half[words[i] + 7'h02] = 16'h0000;
    end
    repeat (5) @(negedge clock_i);
    rst_i = 1'b0;
    do_read(7'h70);
    do_read(7'h58);
    do_read(7'h00);
    check_all();
    $display("test reset done");
    for (int i = 0; i < 25; i++) begin
      a = words[i % 5];
      lo = (a == 7'h78) ? 16'($urandom_range(8191)) - 16'h0800 : 16'($urandom_range(4095));
      hi = (a == 7'h78) ? 16'($urandom_range(8191)) - 16'h0800 : 16'($urandom_range(4095));
      if (i < 5) begin
        lo = (a == 7'h78) ? 16'hF800 : 16'h0000;
        hi = (a == 7'h78) ? 16'h17FF : 16'h0FFF;
      end
      do_write(a, {hi, lo}, (i < 5) ? 4'hF : 4'($urandom_range(15)));
      do_read(a);
    end
    check_all();
    $display("test coordinates done");
    do_write(dcs_pkg::OFS_FG_COLOR, $urandom, 4'hF);
    do_write(dcs_pkg::OFS_BG_COLOR, $urandom, 4'hF);
    for (int f = 0; f < 16; f++) begin
      big_endian_i = 1'($urandom_range(1));
      bpp_log2_i = 6'($urandom_range(5));
      src_pixel_nonzero_i = 1'($urandom_range(1));
      w = $urandom;
      w[27:24] = 4'(f);
      d = big_endian_i ? swap32(w) : w;
      do_write(dcs_pkg::OFS_PIXEL_OP, d, 4'hF);
      check_all();
      big_endian_i = 1'b0;
      do_write(dcs_pkg::OFS_LINE_STEP, $urandom, 4'h8);
      do_write(dcs_pkg::OFS_PIXEL_OP, ~d, 4'hF);
      check_all();
      finish_op();
      check_all();
    end
    $display("test functions done");
    for (int e = 0; e < 2; e++) begin
      big_endian_i = e[0];
      w = $urandom;
      w[27:24] = 4'h8;
      d = e[0] ? swap32(w) : w;
      for (int k = 0; k < 4; k++) begin
        // Register byte 3 always goes last
        l = e[0] ? 3 - k : k;
        do_write(dcs_pkg::OFS_PIXEL_OP, d, 4'(1 << l));
      end
      check_all();
      finish_op();
    end
    $display("test byte lanes done");
    // Reset in mid-run, with a block transfer still running
    do_write(dcs_pkg::OFS_PIXEL_OP, d, 4'hF);
    rst_i = 1'b1;
    repeat (5) @(negedge clock_i);
    rst_i = 1'b0;
    m_pop = 32'h0;
    m_fg = 32'h0;
    m_bg = 32'h0;
    m_busy = 1'b0;
    foreach (m_half[j]) m_half[j] = 16'h0000;
    check_flag(busy_o, 1'b0, "busy after reset");
    check_all();
    do_read(7'h78);
    $display("test mid reset done");
    tally_and_finish();
  end
endmodule : test_dcs_setup_regs
